// file: hw/sdr_host.sv
// host end: axi4-lite command registers driving the serial master
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module sdr_host
  import sdr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  sdr_link_if.host link
);
  typedef enum logic {SDR_IDLE, SDR_SHIFT} sdr_state_e;

  // ==========================================
  // axi state
  logic [3:0] awa_ff, nxt_awa;
  logic awh_ff, nxt_awh;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0] ws_ff, nxt_ws;
  logic wh_ff, nxt_wh;
  logic bv_ff, nxt_bv;
  logic [1:0] br_ff, nxt_br;
  logic arr_ff, nxt_arr;
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0] rr_ff, nxt_rr;
  logic [31:0] cmd_ff, nxt_cmd;
  logic refused_ff, nxt_refused;
  logic awrdy_ff, nxt_awrdy;
  logic wrdy_ff, nxt_wrdy;
  // ==========================================
  // serial state
  sdr_state_e st_ff, nxt_st;
  logic [7:0] div_ff, nxt_div;
  logic [4:0] bit_ff, nxt_bit;
  logic [23:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] rdat_ff, nxt_rdat;
  logic sclk_ff, nxt_sclk;
  logic csb_ff, nxt_csb;
  logic sdo_ff, nxt_sdo;
  logic soe_ff, nxt_soe;
  logic start;
  logic [31:0] cmd_m;
  logic [12:0] ca;
  logic [15:0] instr;
  logic [7:0] dbyte;

  assign s_axi_awready = awrdy_ff;
  assign s_axi_wready = wrdy_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign link.sclk = sclk_ff;
  assign link.csb = csb_ff;
  assign link.host_sdio_o = sdo_ff;
  assign link.host_sdio_oe = soe_ff;

  // merge write strobes into the held command word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      cmd_m[8*b +: 8] = ws_ff[b] ? wd_ff[8*b +: 8] : cmd_ff[8*b +: 8];
    end
  end
  assign ca = cmd_m[CMD_ADDR_LSB +: 13];
  assign start = awh_ff && wh_ff && !bv_ff && awa_ff == H_CMD
    && st_ff == SDR_IDLE && is_mapped(ca);
  assign instr = {cmd_m[CMD_READ], 2'h0, ca};
  assign dbyte = cmd_m[7:0] & wr_mask(ca);

  // ==========================================
  // axi4-lite slave
  always_comb begin
    nxt_awa = awa_ff;
    nxt_awh = awh_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_wh = wh_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_arr = arr_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_cmd = cmd_ff;
    nxt_refused = refused_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awa = s_axi_awaddr;
      nxt_awh = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
      nxt_wh = 1'b1;
    end
    if (awh_ff && wh_ff && !bv_ff) begin
      nxt_awh = 1'b0;
      nxt_wh = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      if (awa_ff == H_CMD) begin
        nxt_cmd = cmd_m;
        // busy or open address: command dropped, flag kept
        nxt_refused = !start;
      end else if (awa_ff != H_STAT) begin
        nxt_br = RESP_DECERR;
      end
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (s_axi_arvalid && arr_ff) begin
      nxt_arr = 1'b0;
      nxt_rv = 1'b1;
      nxt_rr = RESP_OKAY;
      nxt_rd = 32'h0;
      if (s_axi_araddr == H_CMD) begin
        nxt_rd = cmd_ff;
      end else if (s_axi_araddr == H_STAT) begin
        nxt_rd[7:0] = rdat_ff;
        nxt_rd[STAT_BUSY] = st_ff != SDR_IDLE;
        nxt_rd[STAT_REFUSED] = refused_ff;
      end else begin
        nxt_rr = RESP_DECERR;
      end
    end
    if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
      nxt_arr = 1'b1;
    end
    if (!aresetn) begin
      nxt_awh = 1'b0;
      nxt_wh = 1'b0;
      nxt_bv = 1'b0;
      nxt_arr = 1'b0;
      nxt_rv = 1'b0;
      nxt_cmd = 32'h0;
      nxt_refused = 1'b0;
    end else if (!arr_ff && !rv_ff && !(s_axi_arvalid && arr_ff)) begin
      nxt_arr = 1'b1;
    end
    // ready taken from a flop; equals the held and response terms
    nxt_awrdy = aresetn && !nxt_awh && !nxt_bv;
    nxt_wrdy = aresetn && !nxt_wh && !nxt_bv;
  end

  // ==========================================
  // serial master, msb or lsb first per command
  always_comb begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_bit = bit_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_rdat = rdat_ff;
    nxt_sclk = sclk_ff;
    nxt_csb = csb_ff;
    nxt_sdo = sdo_ff;
    nxt_soe = soe_ff;
    case (st_ff)
      SDR_IDLE: begin
        if (start) begin
          nxt_tx = cmd_m[CMD_LSB] ? {rev16(instr), rev8(dbyte)}
            : {instr, dbyte};
          nxt_sdo = cmd_m[CMD_LSB] ? instr[0] : instr[15];
          nxt_soe = 1'b1;
          nxt_csb = 1'b0;
          nxt_bit = 5'h00;
          nxt_div = 8'(SCLK_HALF_CYC - 1);
          nxt_st = SDR_SHIFT;
        end
      end
      default: begin
        nxt_div = 8'(div_ff - 8'h01);
        if (div_ff == 8'h00) begin
          nxt_div = 8'(SCLK_HALF_CYC - 1);
          if (!sclk_ff) begin
            nxt_sclk = 1'b1;
            if (bit_ff > INSTR_LAST) nxt_rx = {rx_ff[6:0], link.sdio};
          end else begin
            nxt_sclk = 1'b0;
            if (bit_ff == FRAME_LAST) begin
              nxt_csb = 1'b1;
              nxt_soe = 1'b0;
              if (cmd_ff[CMD_READ]) begin
                nxt_rdat = cmd_ff[CMD_LSB] ? rev8(rx_ff) : rx_ff;
              end
              nxt_st = SDR_IDLE;
            end else begin
              nxt_bit = 5'(bit_ff + 5'h01);
              nxt_tx = {tx_ff[22:0], 1'b0};
              nxt_sdo = tx_ff[22];
              nxt_soe = !(cmd_ff[CMD_READ] && bit_ff >= INSTR_LAST);
            end
          end
        end
      end
    endcase
    if (!aresetn) begin
      nxt_st = SDR_IDLE;
      nxt_sclk = 1'b0;
      nxt_csb = 1'b1;
      nxt_sdo = 1'b0;
      nxt_soe = 1'b0;
      nxt_rdat = 8'h00;
      nxt_div = 8'h00;
      nxt_bit = 5'h00;
    end
  end

  always_ff @(posedge aclk) begin
    awa_ff <= nxt_awa;
    awh_ff <= nxt_awh;
    wd_ff <= nxt_wd;
    ws_ff <= nxt_ws;
    wh_ff <= nxt_wh;
    bv_ff <= nxt_bv;
    br_ff <= nxt_br;
    arr_ff <= nxt_arr;
    rv_ff <= nxt_rv;
    rd_ff <= nxt_rd;
    rr_ff <= nxt_rr;
    cmd_ff <= nxt_cmd;
    refused_ff <= nxt_refused;
    awrdy_ff <= nxt_awrdy;
    wrdy_ff <= nxt_wrdy;
    st_ff <= nxt_st;
    div_ff <= nxt_div;
    bit_ff <= nxt_bit;
    tx_ff <= nxt_tx;
    rx_ff <= nxt_rx;
    rdat_ff <= nxt_rdat;
    sclk_ff <= nxt_sclk;
    csb_ff <= nxt_csb;
    sdo_ff <= nxt_sdo;
    soe_ff <= nxt_soe;
  end
endmodule // sdr_host
`default_nettype wire

// file: hw/sdr_pkg.sv
// shared constants for the shadowed dual-channel register map and its host
`default_nettype none
package sdr_pkg;
  // ==========================================
  // device map
  localparam logic [12:0] A_PORT_CFG = 13'h000;
  localparam logic [12:0] A_PART_ID = 13'h001;
  localparam logic [12:0] A_SPEED = 13'h002;
  localparam logic [12:0] A_CHAN_SEL = 13'h005;
  localparam logic [12:0] A_COMMIT = 13'h0ff;
  localparam logic [12:0] A_FN_LO = 13'h008;
  localparam logic [12:0] A_FN_HI = 13'h018;
  localparam logic [12:0] A_REF_SEL = 13'h018;
  localparam logic [12:0] A_DIG_LO = 13'h100;
  localparam logic [12:0] A_DIG_HI = 13'h123;
  localparam logic [12:0] A_DSH_LO = 13'h11e;
  localparam int FN_N = 17;
  localparam int DIG_N = 36;
  localparam int DSH_N = 6;
  localparam int DSH_BASE = 30;
  localparam int FN_IDX_CLK = 1;
  localparam int FN_IDX_REF = 16;
  // per-channel function registers: 0x08, 0x0d, 0x10
  localparam logic [16:0] FN_LOCAL_MASK = 17'h00121;
  // ==========================================
  // fields and reset values
  localparam int PC_LSB_HI = 6;
  localparam int PC_LSB_LO = 1;
  localparam int PC_SRST_HI = 5;
  localparam int PC_SRST_LO = 2;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [1:0] CHAN_SEL_RST = 2'h3;
  localparam logic [7:0] REF_SEL_RST = 8'hc0;
  localparam logic [7:0] CLK_RST = 8'h01;
  localparam int COMMIT_BIT = 0;
  localparam int GRADE_LSB = 3;
  // arbitrary identification value
  localparam logic [7:0] PART_ID_DEF = 8'h5a;
  localparam logic [1:0] SPEED_GRADE_DEF = 2'h0;
  // ==========================================
  // serial frame and timing
  localparam int RW_BIT = 15;
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_END = 5'h18;
  localparam int CLK_NS = 20;
  localparam int SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================
  // host registers on axi4-lite
  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_STAT = 4'h4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ = 24;
  localparam int CMD_LSB = 28;
  localparam int STAT_BUSY = 8;
  localparam int STAT_REFUSED = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
  endfunction

  function automatic logic is_mapped(input logic [12:0] a);
    is_mapped = (a <= A_SPEED) || (a == A_CHAN_SEL) || (a == A_COMMIT)
      || (a >= A_FN_LO && a <= A_FN_HI)
      || (a >= A_DIG_LO && a <= A_DIG_HI);
  endfunction

  // bits that carry meaning at each address; the rest go out as zero
  function automatic logic [7:0] wr_mask(input logic [12:0] a);
    if (a == A_PORT_CFG) wr_mask = 8'h7e;
    else if (a == A_CHAN_SEL) wr_mask = 8'h03;
    else if (a == A_COMMIT) wr_mask = 8'h01;
    else if (a == A_REF_SEL) wr_mask = 8'hc0;
    else wr_mask = 8'hff;
  endfunction
endpackage
`default_nettype wire

// file: hw/sdr_link_if.sv
// three-wire serial link between host and register map
`timescale 1ns/1ns
`default_nettype none
interface sdr_link_if;
  logic sclk;
  logic csb;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  // resolved wire level, pulled high when nobody drives
  assign sdio = host_sdio_oe ? host_sdio_o :
    (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport host (output sclk, output csb, output host_sdio_o,
    output host_sdio_oe, input sdio);
  modport dev (input sclk, input csb, input sdio, output dev_sdio_o,
    output dev_sdio_oe);
endinterface
`default_nettype wire

// file: hw/sdr_dev.sv
// register map end: serial slave, shadowed and per-channel registers
`timescale 1ns/1ns
`default_nettype none
module sdr_dev
  import sdr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  sdr_link_if.dev link,
  // operating copies for the converter core; bit order and commit pulse
  input wire logic op_chan,
  input wire logic [4:0] op_idx,
  output logic [7:0] op_fn_data,
  output logic [7:0] op_dsh_data,
  output logic lsb_first,
  output logic commit
);
  // ==========================================
  // serial framing
  logic sclk_q_ff;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] sh_ff, nxt_sh;
  logic [15:0] instr_ff, nxt_instr;
  logic [7:0] tx_ff, nxt_tx;
  logic oe_ff, nxt_oe;
  logic sdo_ff, nxt_sdo;
  logic rise;
  logic fall;
  logic [15:0] instr_now;
  logic [7:0] wdat;
  logic wr_en;
  logic [12:0] wa;
  logic [7:0] rd_val;

  // ==========================================
  // register state
  logic [7:0] pcfg_ff, nxt_pcfg;
  logic [1:0] csel_ff, nxt_csel;
  logic commit_ff, nxt_commit;
  logic [7:0] hold_ff [2][FN_N];
  logic [7:0] nxt_hold [2][FN_N];
  logic [7:0] act_ff [2][FN_N];
  logic [7:0] nxt_act [2][FN_N];
  logic [7:0] dig_ff [DIG_N];
  logic [7:0] nxt_dig [DIG_N];
  logic [7:0] dact_ff [DSH_N];
  logic [7:0] nxt_dact [DSH_N];
  logic [7:0] op_fn_ff, nxt_op_fn;
  logic [7:0] op_dsh_ff, nxt_op_dsh;
  logic init;
  logic fidx_ok;
  logic [4:0] fidx;
  logic [5:0] didx;

  // link signals are synchronous to aclk; edges found by one delay
  assign rise = link.sclk && !sclk_q_ff && !link.csb;
  assign fall = !link.sclk && sclk_q_ff && !link.csb;
  assign lsb_first = pcfg_ff[PC_LSB_HI];
  assign instr_now = lsb_first ? rev16({sh_ff[14:0], link.sdio})
    : {sh_ff[14:0], link.sdio};
  assign wdat = lsb_first ? rev8({sh_ff[6:0], link.sdio})
    : {sh_ff[6:0], link.sdio};
  assign wa = instr_ff[12:0];
  assign wr_en = rise && (cnt_ff == FRAME_LAST) && !instr_ff[RW_BIT];
  assign fidx = 5'(wa - A_FN_LO);
  assign didx = 6'(wa - A_DIG_LO);
  assign link.dev_sdio_o = sdo_ff;
  assign link.dev_sdio_oe = oe_ff;
  assign op_fn_data = op_fn_ff;
  assign op_dsh_data = op_dsh_ff;
  assign commit = commit_ff;

  // ==========================================
  // read decode for the address just received
  always_comb begin
    logic [12:0] ra;
    logic [4:0] ri;
    logic [5:0] rj;
    ra = instr_now[12:0];
    ri = 5'(ra - A_FN_LO);
    rj = 6'(ra - A_DIG_LO);
    rd_val = 8'h00;
    if (ra == A_PORT_CFG) begin
      rd_val = pcfg_ff;
    end else if (ra == A_PART_ID) begin
      rd_val = PART_ID_DEF;
    end else if (ra == A_SPEED) begin
      rd_val = 8'(SPEED_GRADE_DEF) << GRADE_LSB;
    end else if (ra == A_CHAN_SEL) begin
      rd_val = {6'h00, csel_ff};
    end else if (ra == A_COMMIT) begin
      rd_val = {7'h00, commit_ff};
    end else if (ra >= A_FN_LO && ra <= A_FN_HI) begin
      // channel a wins when both are selected
      rd_val = csel_ff[0] ? hold_ff[0][ri] : hold_ff[1][ri];
    end else if (ra >= A_DIG_LO && ra <= A_DIG_HI) begin
      rd_val = dig_ff[rj];
    end
  end

  // ==========================================
  // shift engine
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_instr = instr_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_sdo = sdo_ff;
    if (!aresetn || link.csb) begin
      nxt_cnt = 5'h00;
      nxt_oe = 1'b0;
      nxt_sdo = 1'b0;
      if (!aresetn) begin
        nxt_sh = 16'h0000;
        nxt_instr = 16'h0000;
        nxt_tx = 8'h00;
      end
    end else if (rise) begin
      nxt_sh = {sh_ff[14:0], link.sdio};
      // extra bits after one data byte are ignored
      if (cnt_ff != FRAME_END) nxt_cnt = 5'(cnt_ff + 5'h01);
      if (cnt_ff == INSTR_LAST) begin
        nxt_instr = instr_now;
        nxt_tx = lsb_first ? rev8(rd_val) : rd_val;
      end
    end else if (fall) begin
      if (instr_ff[RW_BIT] && cnt_ff > INSTR_LAST
          && cnt_ff < FRAME_END) begin
        nxt_oe = 1'b1;
        nxt_sdo = tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b0};
      end else begin
        nxt_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    sclk_q_ff <= aresetn ? link.sclk : 1'b0;
    cnt_ff <= nxt_cnt;
    sh_ff <= nxt_sh;
    instr_ff <= nxt_instr;
    tx_ff <= nxt_tx;
    oe_ff <= nxt_oe;
    sdo_ff <= nxt_sdo;
  end

  // ==========================================
  // register file
  // soft reset reloads the same defaults as the reset pin
  assign init = !aresetn || (wr_en && wa == A_PORT_CFG
    && (wdat[PC_SRST_HI] || wdat[PC_SRST_LO]));
  assign fidx_ok = op_idx < 5'(FN_N);

  always_comb begin
    nxt_pcfg = pcfg_ff;
    nxt_csel = csel_ff;
    nxt_hold = hold_ff;
    nxt_act = act_ff;
    nxt_dig = dig_ff;
    nxt_dact = dact_ff;
    nxt_commit = 1'b0;
    if (init) begin
      nxt_pcfg = PORT_CFG_RST;
      nxt_csel = CHAN_SEL_RST;
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < FN_N; i++) begin
          nxt_hold[c][i] = 8'h00;
          nxt_act[c][i] = 8'h00;
        end
        nxt_hold[c][FN_IDX_CLK] = CLK_RST;
        nxt_act[c][FN_IDX_CLK] = CLK_RST;
        nxt_hold[c][FN_IDX_REF] = REF_SEL_RST;
        nxt_act[c][FN_IDX_REF] = REF_SEL_RST;
      end
      for (int i = 0; i < DIG_N; i++) nxt_dig[i] = 8'h00;
      for (int i = 0; i < DSH_N; i++) nxt_dact[i] = 8'h00;
    end else begin
      // operating copies move together, one cycle after the commit write
      if (commit_ff) begin
        nxt_act = hold_ff;
        for (int i = 0; i < DSH_N; i++) begin
          nxt_dact[i] = dig_ff[DSH_BASE + i];
        end
      end
      if (wr_en) begin
        if (wa == A_PORT_CFG) begin
          // either mirrored bit sets the order; fixed ones stay
          nxt_pcfg = PORT_CFG_RST;
          nxt_pcfg[PC_LSB_HI] = wdat[PC_LSB_HI] | wdat[PC_LSB_LO];
          nxt_pcfg[PC_LSB_LO] = wdat[PC_LSB_HI] | wdat[PC_LSB_LO];
        end else if (wa == A_CHAN_SEL) begin
          nxt_csel = wdat[1:0];
        end else if (wa == A_COMMIT) begin
          nxt_commit = wdat[COMMIT_BIT];
        end else if (wa >= A_FN_LO && wa <= A_FN_HI) begin
          for (int c = 0; c < 2; c++) begin
            // globals keep both copies equal, so selects do not matter
            if (csel_ff[c] || !FN_LOCAL_MASK[fidx]) begin
              nxt_hold[c][fidx] = wdat;
            end
          end
        end else if (wa >= A_DIG_LO && wa <= A_DIG_HI) begin
          nxt_dig[didx] = wdat;
        end
        // identification and grade writes fall through untouched
      end
    end
  end

  // operating view for the core, read from the committed copies
  always_comb begin
    nxt_op_fn = fidx_ok ? act_ff[op_chan][op_idx] : 8'h00;
    nxt_op_dsh = (op_idx < 5'(DSH_N)) ? dact_ff[op_idx[2:0]] : 8'h00;
  end

  always_ff @(posedge aclk) begin
    pcfg_ff <= nxt_pcfg;
    csel_ff <= nxt_csel;
    hold_ff <= nxt_hold;
    act_ff <= nxt_act;
    dig_ff <= nxt_dig;
    dact_ff <= nxt_dact;
    commit_ff <= nxt_commit;
    op_fn_ff <= aresetn ? nxt_op_fn : 8'h00;
    op_dsh_ff <= aresetn ? nxt_op_dsh : 8'h00;
  end
endmodule // sdr_dev
`default_nettype wire

// file: testbench/sdr_link_checker.sv
// concurrent checks on the serial link between host and register map
`timescale 1ns/1ns
`default_nettype none
module sdr_link_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link and device status
  input wire logic sclk,
  input wire logic csb,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe,
  input wire logic lsb_first,
  input wire logic commit
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // sequences
  sequence idle_line;
    csb && !dev_sdio_oe && !host_sdio_oe;
  endsequence
  // one serial half period is five system clocks
  sequence half_high;
    sclk [*5] ##1 !sclk;
  endsequence
  // ==========================================
  // link rules
  rst_idle_a: assert property (
    $rose(aresetn) |-> idle_line ##0 !lsb_first && !commit)
    else $error("link not idle after reset");
  no_fight_a: assert property (
    !(host_sdio_oe && dev_sdio_oe)) else $error("both ends drive data");
  dev_release_a: assert property (
    $rose(csb) |=> !dev_sdio_oe) else $error("device holds data line");
  dev_turn_a: assert property (
    $rose(dev_sdio_oe) |-> !sclk && !csb) else $error("bad turnaround");
  sclk_idle_a: assert property (
    csb && $past(csb) |-> !sclk) else $error("clock runs outside frame");
  frame_start_a: assert property (
    $fell(csb) |-> host_sdio_oe && !sclk) else $error("bad frame start");
  sclk_half_a: assert property (
    $rose(sclk) |-> half_high) else $error("clock half period wrong");
  commit_pulse_a: assert property (
    commit |=> !commit) else $error("commit bit not cleared");
  commit_frame_a: assert property (
    $rose(commit) |-> !csb) else $error("commit outside a frame");
  order_frame_a: assert property (
    $changed(lsb_first) |-> !csb) else $error("bit order moved idle");
endmodule // sdr_link_checker
`default_nettype wire

// file: testbench/shadowed_dual_channel_register_map_test.sv
// self-checking bench for host and register map joined by the link
`timescale 1ns/1ns
`default_nettype none
module shadowed_dual_channel_register_map_test;
  import sdr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, op_chan, lsb;
  logic lsb_first, commit;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, s;
  logic [1:0] bresp, rresp, r;
  logic [4:0] op_idx;
  logic [7:0] op_fn_data, op_dsh_data;
  int fails, comparisons;
  // ==========================================
  // ends, link and checker
  sdr_link_if sdr_link_if_i ();
  sdr_host sdr_host_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(sdr_link_if_i.host));
  sdr_dev sdr_dev_i (.aclk(aclk), .aresetn(aresetn),
    .link(sdr_link_if_i.dev), .op_chan(op_chan), .op_idx(op_idx),
    .op_fn_data(op_fn_data), .op_dsh_data(op_dsh_data),
    .lsb_first(lsb_first), .commit(commit));
  sdr_link_checker sdr_link_checker_i (.aclk(aclk), .aresetn(aresetn),
    .sclk(sdr_link_if_i.sclk), .csb(sdr_link_if_i.csb),
    .host_sdio_oe(sdr_link_if_i.host_sdio_oe),
    .dev_sdio_oe(sdr_link_if_i.dev_sdio_oe),
    .lsb_first(lsb_first), .commit(commit));
  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    s = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // busy is polled, so no frame length is assumed here
  task automatic dop(input logic rd, input logic [12:0] a,
      input logic [7:0] d);
    axw(H_CMD, {3'h0, lsb, 3'h0, rd, 3'h0, a, d});
    s = 32'h100;
    // one edge between polls so ready is never lowered and raised at once
    while (s[STAT_BUSY]) begin
      axr(H_STAT);
      @(posedge aclk);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    dop(1'h0, a, d);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    dop(1'h1, a, 8'h00);
    chk(s[7:0], e);
  endtask
  task automatic opc(input logic ch, input logic [4:0] i);
    op_chan <= ch;
    op_idx <= i;
    repeat (2) @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and tests
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    report_and_stop();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, op_chan} = 7'h00;
    {awaddr, araddr, wdata, op_idx, lsb} = 46'h0;
    wstrb = 4'hf;
    fails = 0;
    comparisons = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(A_PORT_CFG, 8'h18);
    rd(A_CHAN_SEL, 8'h03);
    rd(A_REF_SEL, 8'hc0);
    wr(A_PART_ID, 8'hff);
    rd(A_PART_ID, PART_ID_DEF);
    rd(A_SPEED, {3'h0, SPEED_GRADE_DEF, 3'h0});
    wr(13'h123, 8'h77);
    rd(13'h123, 8'h77);
    dop(1'h1, 13'h003, 8'h00);
    chk({7'h0, s[STAT_REFUSED]}, 8'h01);
    axw(4'h8, 32'h0);
    chk({6'h0, r}, {6'h0, RESP_DECERR});
    axr(4'h8);
    chk({6'h0, r}, {6'h0, RESP_DECERR});
    // shadowed writes stay out of the operating copy until commit
    opc(1'h0, 5'h10);
    chk(op_fn_data, 8'hc0);
    wr(A_REF_SEL, 8'h7f);
    wr(13'h11e, 8'h5a);
    rd(A_REF_SEL, 8'h40);
    chk(op_fn_data, 8'hc0);
    wr(A_COMMIT, 8'h01);
    rd(A_COMMIT, 8'h00);
    opc(1'h1, 5'h10);
    chk(op_fn_data, 8'h40);
    opc(1'h0, 5'h00);
    chk(op_dsh_data, 8'h5a);
    // per-channel copies
    wr(A_CHAN_SEL, 8'h01);
    wr(A_FN_LO, 8'h11);
    wr(A_CHAN_SEL, 8'h02);
    wr(A_FN_LO, 8'h22);
    wr(13'h009, 8'h44);
    rd(A_FN_LO, 8'h22);
    wr(A_CHAN_SEL, 8'h03);
    rd(A_FN_LO, 8'h11);
    wr(13'h00d, 8'h33);
    wr(A_CHAN_SEL, 8'h02);
    rd(13'h00d, 8'h33);
    wr(A_CHAN_SEL, 8'h01);
    rd(13'h009, 8'h44);
    wr(A_COMMIT, 8'h01);
    opc(1'h1, 5'h00);
    chk(op_fn_data, 8'h22);
    opc(1'h0, 5'h00);
    chk(op_fn_data, 8'h11);
    // bit order and soft reset
    wr(A_PORT_CFG, 8'h42);
    chk({7'h0, lsb_first}, 8'h01);
    lsb = 1'h1;
    rd(A_PORT_CFG, 8'h5a);
    rd(A_CHAN_SEL, 8'h01);
    wr(A_PORT_CFG, 8'h24);
    chk({7'h0, lsb_first}, 8'h00);
    lsb = 1'h0;
    rd(A_CHAN_SEL, 8'h03);
    rd(A_PORT_CFG, 8'h18);
    report_and_stop();
  end
endmodule // shadowed_dual_channel_register_map_test
`default_nettype wire
